// ---- pkg/sfbp_pkg.sv ----
package sfbp_pkg;

	// wishbone request side, travels as one bundle
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [9:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} sfbp_wb_req_t;

	// all state of the slave
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [7:0] idx;
	} sfbp_state_t;

	localparam sfbp_state_t STATE_RST = '{ack: 1'b0, dat: 32'h0000_0000, idx: 8'h00};

	// word offsets of the parameter table and header pointer
	localparam logic [9:0] OFS_HDR = 10'h00c;
	localparam logic [9:0] OFS_ERASE4K = 10'h030;
	localparam logic [9:0] OFS_DENS = 10'h034;
	localparam logic [9:0] OFS_FR_QUAD = 10'h038;
	localparam logic [9:0] OFS_FR_DUAL = 10'h03c;
	localparam logic [9:0] OFS_FR_SUP = 10'h040;
	localparam logic [9:0] OFS_FR222 = 10'h044;
	localparam logic [9:0] OFS_FR444 = 10'h048;
	localparam logic [9:0] OFS_ET12 = 10'h04c;
	localparam logic [9:0] OFS_ET34 = 10'h050;
	localparam logic [9:0] OFS_ETIME = 10'h054;
	// byte view registers
	localparam logic [9:0] OFS_IDX = 10'h100;
	localparam logic [9:0] OFS_BYTE = 10'h104;
	localparam logic [9:0] OFS_STAT = 10'h108;

	// header pointer and id msb
	localparam logic [23:0] HDR_PTR = 24'h00_0030;
	localparam logic [7:0] HDR_ID_MSB = 8'hff;

	// granularity byte
	localparam logic [1:0] ERASE_GRAN = 2'h1;
	localparam logic WR_GRAN = 1'h1;
	localparam logic VOL_BP = 1'h0;
	localparam logic WREN_SEL = 1'h0;
	localparam logic [2:0] ONES3 = 3'h7;
	localparam logic ONE1 = 1'h1;
	localparam logic [7:0] ONES8 = 8'hff;
	localparam logic [7:0] OP_ERASE4K = 8'h20;

	// read mode support
	localparam logic [1:0] ADDR_BYTES = 2'h1;
	localparam logic SUP_112 = 1'h1;
	localparam logic SUP_DTR = 1'h1;
	localparam logic SUP_122 = 1'h1;
	localparam logic SUP_144 = 1'h1;
	localparam logic SUP_114 = 1'h1;
	localparam logic SUP_222 = 1'h0;
	localparam logic SUP_444 = 1'h1;
	localparam logic [31:0] DENSITY = 32'h1fff_ffff;

	// wait cycles, mode cycles, opcode per read mode
	localparam logic [4:0] WAIT_144 = 5'h04;
	localparam logic [2:0] MODE_144 = 3'h2;
	localparam logic [7:0] OP_144 = 8'heb;
	localparam logic [4:0] WAIT_114 = 5'h08;
	localparam logic [2:0] MODE_114 = 3'h0;
	localparam logic [7:0] OP_114 = 8'h6b;
	localparam logic [4:0] WAIT_112 = 5'h08;
	localparam logic [2:0] MODE_112 = 3'h0;
	localparam logic [7:0] OP_112 = 8'h3b;
	localparam logic [4:0] WAIT_122 = 5'h00;
	localparam logic [2:0] MODE_122 = 3'h4;
	localparam logic [7:0] OP_122 = 8'hbb;
	localparam logic [4:0] WAIT_222 = 5'h00;
	localparam logic [2:0] MODE_222 = 3'h0;
	localparam logic [7:0] OP_222 = 8'hff;
	localparam logic [4:0] WAIT_444 = 5'h04;
	localparam logic [2:0] MODE_444 = 3'h2;
	localparam logic [7:0] OP_444 = 8'heb;

	// erase types: size exponent and opcode, standard and large-block sets
	localparam logic [7:0] ET1_SIZE = 8'h0c;
	localparam logic [7:0] ET1_OP = 8'h20;
	localparam logic [7:0] ET2_SIZE = 8'h0f;
	localparam logic [7:0] ET2_OP = 8'h52;
	localparam logic [7:0] ET3_SIZE_STD = 8'h10;
	localparam logic [7:0] ET3_OP_STD = 8'hd8;
	localparam logic [7:0] ET3_SIZE_LB = 8'h00;
	localparam logic [7:0] ET3_OP_LB = 8'hff;
	localparam logic [7:0] ET4_SIZE_STD = 8'h00;
	localparam logic [7:0] ET4_OP_STD = 8'hff;
	localparam logic [7:0] ET4_SIZE_LB = 8'h12;
	localparam logic [7:0] ET4_OP_LB = 8'hd8;

	// typical erase times: count and units
	localparam logic [3:0] ERASE_MULT = 4'h2;
	localparam logic [4:0] T1_CNT = 5'h06;
	localparam logic [1:0] T1_UNIT = 2'h1;
	localparam logic [4:0] T2_CNT = 5'h08;
	localparam logic [1:0] T2_UNIT = 2'h1;
	localparam logic [4:0] T3_CNT_STD = 5'h0a;
	localparam logic [1:0] T3_UNIT_STD = 2'h1;
	localparam logic [4:0] T3_CNT_LB = 5'h00;
	localparam logic [1:0] T3_UNIT_LB = 2'h0;
	localparam logic [4:0] T4_CNT_STD = 5'h00;
	localparam logic [1:0] T4_UNIT_STD = 2'h0;
	localparam logic [4:0] T4_CNT_LB = 5'h05;
	localparam logic [1:0] T4_UNIT_LB = 2'h2;

endpackage

// ---- rtl/sfbp_rom.sv ----
// Functional notes
// - byte 30h: 4KB erase, page write granularity
// - byte 30h bits 3,4 zero, 7:5 ones
// - 4KB erase opcode 20h at 31h, 4Dh
// - byte 4Ch holds type-1 size exponent 0Ch
// - byte 32h read modes, DTR, address bytes
// - byte 33h FFh, density word 1FFFFFFFh
// - 1-4-4 read: 4 wait, 2 mode, EBh
// - 1-1-4 read: 8 wait, 0 mode, 6Bh
// - 1-1-2 read: 8 wait, 0 mode, 3Bh
// - 1-2-2 read: 0 wait, 4 mode, BBh
// - byte 40h: no 2-2-2, has 4-4-4
// - 2-2-2 counts zero, opcode FFh
// - 4-4-4 read: 4 wait, 2 mode, EBh
// - type-2 erase 32KB, opcode 52h
// - type-3 erase 64KB/D8h, absent on large option
// - type-4 erase absent, 256KB/D8h on large option
// - erase time multiplier reads 0010b
// - type-1 and type-2 typical erase times
// - type-3 and type-4 typical erase times per option
// - header pointer bytes read 30h, 00h, 00h
// - option fixed at build to one set
//
// Design decisions made here: register access over Wishbone and the register addresses.
module sfbp_rom #(
	parameter logic LARGE_BLOCK = 1'b0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire sfbp_pkg::sfbp_wb_req_t wb_req_i,
	output logic ack_o,
	output logic [31:0] dat_o
);

	sfbp_pkg::sfbp_state_t s_r;
	sfbp_pkg::sfbp_state_t s_nxt;
	logic take;
	logic rd_take;
	logic [9:0] wadr;

	// one parameter word, little-endian byte order
	function automatic logic [31:0] table_word(input logic [9:0] a, input logic lg);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			sfbp_pkg::OFS_HDR: begin
				w = {sfbp_pkg::HDR_ID_MSB, sfbp_pkg::HDR_PTR};
			end
			sfbp_pkg::OFS_ERASE4K: begin
				w[7:0] = {sfbp_pkg::ONES3, sfbp_pkg::WREN_SEL, sfbp_pkg::VOL_BP,
					sfbp_pkg::WR_GRAN, sfbp_pkg::ERASE_GRAN};
				w[15:8] = sfbp_pkg::OP_ERASE4K;
				w[23:16] = {sfbp_pkg::ONE1, sfbp_pkg::SUP_114, sfbp_pkg::SUP_144,
					sfbp_pkg::SUP_122, sfbp_pkg::SUP_DTR, sfbp_pkg::ADDR_BYTES,
					sfbp_pkg::SUP_112};
				w[31:24] = sfbp_pkg::ONES8;
			end
			sfbp_pkg::OFS_DENS: begin
				w = sfbp_pkg::DENSITY;
			end
			sfbp_pkg::OFS_FR_QUAD: begin
				w[15:0] = {sfbp_pkg::OP_144, sfbp_pkg::MODE_144, sfbp_pkg::WAIT_144};
				w[31:16] = {sfbp_pkg::OP_114, sfbp_pkg::MODE_114, sfbp_pkg::WAIT_114};
			end
			sfbp_pkg::OFS_FR_DUAL: begin
				w[15:0] = {sfbp_pkg::OP_112, sfbp_pkg::MODE_112, sfbp_pkg::WAIT_112};
				w[31:16] = {sfbp_pkg::OP_122, sfbp_pkg::MODE_122, sfbp_pkg::WAIT_122};
			end
			sfbp_pkg::OFS_FR_SUP: begin
				w[7:0] = {sfbp_pkg::ONES3, sfbp_pkg::SUP_444, sfbp_pkg::ONES3,
					sfbp_pkg::SUP_222};
				w[31:8] = {3{sfbp_pkg::ONES8}};
			end
			sfbp_pkg::OFS_FR222: begin
				w[15:0] = {2{sfbp_pkg::ONES8}};
				w[31:16] = {sfbp_pkg::OP_222, sfbp_pkg::MODE_222, sfbp_pkg::WAIT_222};
			end
			sfbp_pkg::OFS_FR444: begin
				w[15:0] = {2{sfbp_pkg::ONES8}};
				w[31:16] = {sfbp_pkg::OP_444, sfbp_pkg::MODE_444, sfbp_pkg::WAIT_444};
			end
			sfbp_pkg::OFS_ET12: begin
				w[15:0] = {sfbp_pkg::ET1_OP, sfbp_pkg::ET1_SIZE};
				w[31:16] = {sfbp_pkg::ET2_OP, sfbp_pkg::ET2_SIZE};
			end
			sfbp_pkg::OFS_ET34: begin
				if (lg) begin
					// large-block set: 64KB slot absent, 256KB slot filled
					w = {sfbp_pkg::ET4_OP_LB, sfbp_pkg::ET4_SIZE_LB,
						sfbp_pkg::ET3_OP_LB, sfbp_pkg::ET3_SIZE_LB};
				end else begin
					w = {sfbp_pkg::ET4_OP_STD, sfbp_pkg::ET4_SIZE_STD,
						sfbp_pkg::ET3_OP_STD, sfbp_pkg::ET3_SIZE_STD};
				end
			end
			sfbp_pkg::OFS_ETIME: begin
				w[3:0] = sfbp_pkg::ERASE_MULT;
				w[17:4] = {sfbp_pkg::T2_UNIT, sfbp_pkg::T2_CNT,
					sfbp_pkg::T1_UNIT, sfbp_pkg::T1_CNT};
				if (lg) begin
					w[31:18] = {sfbp_pkg::T4_UNIT_LB, sfbp_pkg::T4_CNT_LB,
						sfbp_pkg::T3_UNIT_LB, sfbp_pkg::T3_CNT_LB};
				end else begin
					w[31:18] = {sfbp_pkg::T4_UNIT_STD, sfbp_pkg::T4_CNT_STD,
						sfbp_pkg::T3_UNIT_STD, sfbp_pkg::T3_CNT_STD};
				end
			end
			default: begin
				w = 32'h0000_0000;
			end
		endcase
		return w;
	endfunction

	// one table byte, picked from its word the way the host assembles them
	function automatic logic [7:0] table_byte(input logic [7:0] i, input logic lg);
		logic [31:0] w;
		w = table_word({2'b00, i[7:2], 2'b00}, lg);
		case (i[1:0])
			2'b00: return w[7:0];
			2'b01: return w[15:8];
			2'b10: return w[23:16];
			default: return w[31:24];
		endcase
	endfunction

	// a request is taken once; the ack cycle itself never starts a second one
	assign take = wb_req_i.cyc & wb_req_i.stb & ~s_r.ack;
	assign rd_take = take & ~wb_req_i.we;
	assign wadr = {wb_req_i.adr[9:2], 2'b00};

	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = 1'b0;
		if (take) begin
			s_nxt.ack = 1'b1;
			s_nxt.dat = 32'h0000_0000;
			if (!wb_req_i.we) begin
				case (wadr)
					sfbp_pkg::OFS_BYTE: begin
						// read pointer steps so a byte walk runs upward
						s_nxt.dat = {24'h00_0000, table_byte(s_r.idx, LARGE_BLOCK)};
						s_nxt.idx = s_r.idx + 8'h01;
					end
					sfbp_pkg::OFS_IDX: begin
						s_nxt.dat = {24'h00_0000, s_r.idx};
					end
					sfbp_pkg::OFS_STAT: begin
						s_nxt.dat = {16'h0000, s_r.idx, 7'h00, LARGE_BLOCK};
					end
					default: begin
						s_nxt.dat = table_word(wadr, LARGE_BLOCK);
					end
				endcase
			end else if (wadr == sfbp_pkg::OFS_IDX && wb_req_i.sel[0]) begin
				s_nxt.idx = wb_req_i.dat[7:0];
			end
			// writes anywhere else are acked and dropped: the table is fixed
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= sfbp_pkg::STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ack_o = s_r.ack;
	assign dat_o = s_r.dat;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held for more than one cycle");
	ack_time_a: assert property (take |=> ack_o)
		else $error("request not acked in the next cycle");
	hdr_ptr_a: assert property (rd_take && wadr == sfbp_pkg::OFS_HDR |=> dat_o[23:0] == 24'h00_0030)
		else $error("header pointer wrong");
	gran_byte_a: assert property (rd_take && wadr == sfbp_pkg::OFS_ERASE4K
		|=> dat_o[15:0] == 16'h20e5)
		else $error("granularity byte or 4KB opcode wrong");
	mode_byte_a: assert property (rd_take && wadr == sfbp_pkg::OFS_ERASE4K
		|=> dat_o[31:16] == 16'hfffb)
		else $error("read mode support byte wrong");
	density_a: assert property (rd_take && wadr == sfbp_pkg::OFS_DENS |=> dat_o == 32'h1fff_ffff)
		else $error("density word wrong");
	quad_read_a: assert property (rd_take && wadr == sfbp_pkg::OFS_FR_QUAD
		|=> dat_o == 32'h6b08_eb44)
		else $error("quad read fields wrong");
	dual_read_a: assert property (rd_take && wadr == sfbp_pkg::OFS_FR_DUAL
		|=> dat_o == 32'hbb80_3b08)
		else $error("dual read fields wrong");
	mode_sup_a: assert property (rd_take && wadr == sfbp_pkg::OFS_FR_SUP
		|=> dat_o == 32'hffff_fffe)
		else $error("2-2-2 or 4-4-4 support wrong");
	qpi_read_a: assert property (rd_take && (wadr == sfbp_pkg::OFS_FR222 || wadr == sfbp_pkg::OFS_FR444)
		|=> dat_o[15:0] == 16'hffff && dat_o[23:16] != 8'h00 == (dat_o[31:24] == 8'heb))
		else $error("quad peripheral read fields wrong");
	erase12_a: assert property (rd_take && wadr == sfbp_pkg::OFS_ET12 |=> dat_o == 32'h520f_200c)
		else $error("erase type 1 or 2 wrong");
	erase34_a: assert property (rd_take && wadr == sfbp_pkg::OFS_ET34
		|=> dat_o == (LARGE_BLOCK ? 32'hd812_ff00 : 32'hff00_d810))
		else $error("erase type 3 or 4 wrong for option");
	erase_time_a: assert property (rd_take && wadr == sfbp_pkg::OFS_ETIME
		|=> dat_o == (LARGE_BLOCK ? 32'h8a01_4262 : 32'h00a9_4262))
		else $error("erase time word wrong");
	byte_walk_a: assert property (rd_take && wadr == sfbp_pkg::OFS_BYTE
		|=> s_r.idx == $past(s_r.idx) + 8'h01 ##0 dat_o[31:8] == 24'h00_0000)
		else $error("byte pointer did not step");
	idx_hold_a: assert property (!take |=> $stable(s_r.idx) && $stable(dat_o))
		else $error("state changed with no request");
	write_drop_a: assert property (take && wb_req_i.we && wadr == sfbp_pkg::OFS_DENS
		##[2:4] rd_take && wadr == sfbp_pkg::OFS_DENS |=> dat_o == 32'h1fff_ffff)
		else $error("table write changed contents");

	table_read_c: cover property (rd_take && wadr == sfbp_pkg::OFS_ET34 ##1 ack_o);
	table_write_c: cover property (take && wb_req_i.we && wadr == sfbp_pkg::OFS_ERASE4K);
	byte_walk_c: cover property (rd_take && wadr == sfbp_pkg::OFS_BYTE ##[2:4]
		rd_take && wadr == sfbp_pkg::OFS_BYTE);
	idx_write_c: cover property (take && wb_req_i.we && wadr == sfbp_pkg::OFS_IDX);

endmodule

// ---- test/sfbp_host.sv ----
module sfbp_host (
	// clock
	input wire logic clk_i,
	// wishbone master side
	output sfbp_pkg::sfbp_wb_req_t req_o,
	input wire logic ack_i,
	input wire logic [31:0] dat_s_i,
	input wire logic [31:0] dat_l_i
);
	timeunit 1ns;
	timeprecision 1ps;

	int timeouts;
	logic [31:0] words_s [0:9];
	logic [31:0] words_l [0:9];

	initial begin
		req_o = '0;
		timeouts = 0;
	end

	task automatic wb_xfer(input logic we, input logic [9:0] adr, input logic [3:0] sel, input logic [31:0] wd,
		output logic [31:0] rs, output logic [31:0] rl);
		int n;
		n = 0;
		@(posedge clk_i);
		req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: wd};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 16);
		if (ack_i !== 1'b1)
			timeouts++;
		rs = dat_s_i;
		rl = dat_l_i;
		// released lines carry the inverse so a stale value never passes for a drive
		req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, adr: ~adr, sel: ~sel, dat: ~wd};
	endtask

	task automatic read_table();
		logic [31:0] s;
		logic [31:0] l;
		wb_xfer(1'b1, 10'h100, 4'h1, 32'h0000_0030, s, l);
		for (int k = 0; k < 40; k++) begin
			wb_xfer(1'b0, 10'h104, 4'hf, 32'h0000_0000, s, l);
			words_s[k / 4][8 * (k % 4) +: 8] = s[7:0];
			words_l[k / 4][8 * (k % 4) +: 8] = l[7:0];
		end
	endtask
endmodule

// ---- test/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i;
	logic rst_i;
	sfbp_pkg::sfbp_wb_req_t req;
	logic ack_s;
	logic ack_l;
	logic [31:0] dat_s;
	logic [31:0] dat_l;
	logic [31:0] rs;
	logic [31:0] rl;
	logic [9:0] a;
	int fails;
	int checks;

	sfbp_rom #(.LARGE_BLOCK(1'b0)) u_sfbp_rom (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .ack_o(ack_s),
		.dat_o(dat_s));
	sfbp_rom #(.LARGE_BLOCK(1'b1)) u_sfbp_rom_lb (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .ack_o(ack_l),
		.dat_o(dat_l));
	sfbp_host u_sfbp_host (.clk_i(clk_i), .req_o(req), .ack_i(ack_s), .dat_s_i(dat_s), .dat_l_i(dat_l));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	function automatic logic [31:0] exp_word(input logic [9:0] adr, input logic lb);
		case (adr)
			10'h00c: exp_word = {8'hff, 24'h00_0030};
			10'h030: exp_word = {8'hff, 5'b11111, 2'b01, 1'b1, 8'h20, 3'b111, 1'b0, 1'b0, 1'b1, 2'b01};
			10'h034: exp_word = {8'h1f, 8'hff, 8'hff, 8'hff};
			10'h038: exp_word = {8'h6b, 3'b000, 5'b01000, 8'heb, 3'b010, 5'b00100};
			10'h03c: exp_word = {8'hbb, 3'b100, 5'b00000, 8'h3b, 3'b000, 5'b01000};
			10'h040: exp_word = {24'hff_ffff, 3'b111, 1'b1, 3'b111, 1'b0};
			10'h044: exp_word = {8'hff, 3'b000, 5'b00000, 16'hffff};
			10'h048: exp_word = {8'heb, 3'b010, 5'b00100, 16'hffff};
			10'h04c: exp_word = {8'h52, 8'h0f, 8'h20, 8'h0c};
			10'h050: exp_word = lb ? {8'hd8, 8'h12, 8'hff, 8'h00} : {8'hff, 8'h00, 8'hd8, 8'h10};
			10'h054: exp_word = {lb ? 14'b10_00101_00_00000 : 14'b00_00000_01_01010,
				2'b01, 5'b01000, 2'b01, 5'b00110, 4'b0010};
			default: exp_word = 32'h0000_0000;
		endcase
	endfunction

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic xfer(input logic we, input logic [9:0] adr, input logic [3:0] sel, input logic [31:0] wd);
		u_sfbp_host.wb_xfer(we, adr, sel, wd, rs, rl);
		if (u_sfbp_host.timeouts != 0) begin
			fails++;
			report_and_stop();
		end
	endtask

	initial begin
		fails = 0;
		checks = 0;
		rst_i = 1'b1;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		chk32({31'h0, ack_s}, 32'h0000_0000);
		chk32({31'h0, ack_l}, 32'h0000_0000);
		chk32(dat_s, 32'h0000_0000);
		chk32(dat_l, 32'h0000_0000);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			a = (i == 0) ? 10'h00c : 10'h02c + 10'(4 * i);
			xfer(1'b0, a, 4'hf, 32'h0000_0000);
			chk32(rs, exp_word(a, 1'b0));
			chk32(rl, exp_word(a, 1'b1));
			xfer(1'b1, a, 4'hf, ~exp_word(a, 1'b0));
			chk32(rs, 32'h0000_0000);
			xfer(1'b0, a, 4'hf, 32'h0000_0000);
			chk32(rs, exp_word(a, 1'b0));
			chk32(rl, exp_word(a, 1'b1));
		end
		@(posedge clk_i);
		chk32({31'h0, ack_s}, 32'h0000_0000);
		$display("test words done");
		u_sfbp_host.read_table();
		for (int k = 0; k < 10; k++) begin
			chk32(u_sfbp_host.words_s[k], exp_word(10'h030 + 10'(4 * k), 1'b0));
			chk32(u_sfbp_host.words_l[k], exp_word(10'h030 + 10'(4 * k), 1'b1));
		end
		xfer(1'b1, 10'h100, 4'he, 32'h0000_0000);
		xfer(1'b0, 10'h108, 4'hf, 32'h0000_0000);
		chk32(rs, 32'h0000_5800);
		chk32(rl, 32'h0000_5801);
		$display("test byte view done");
		xfer(1'b1, 10'h100, 4'h1, 32'h0000_00ff);
		xfer(1'b0, 10'h104, 4'hf, 32'h0000_0000);
		chk32(rs, 32'h0000_0000);
		xfer(1'b0, 10'h108, 4'hf, 32'h0000_0000);
		chk32(rs, 32'h0000_0000);
		xfer(1'b1, 10'h100, 4'h1, 32'h0000_0030);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk32(dat_s, 32'h0000_0000);
		rst_i <= 1'b0;
		xfer(1'b0, 10'h108, 4'hf, 32'h0000_0000);
		chk32(rs, 32'h0000_0000);
		xfer(1'b0, 10'h034, 4'hf, 32'h0000_0000);
		chk32(rs, exp_word(10'h034, 1'b0));
		$display("test wrap and reset done");
		report_and_stop();
	end
endmodule
